// ===== core/hsp_host_ctrl.sv
`timescale 1ns/1ps

module hsp_host_ctrl #(
  parameter int BREAK_CYC       = hsp_pkg::BREAK_CYC,
  parameter int HOST_SLOT_CYC   = hsp_pkg::HOST_SLOT_CYC,
  parameter int RESULT_FILL_CYC = hsp_pkg::RESULT_FILL_CYC,
  parameter int RX_TIMEOUT_CYC  = hsp_pkg::RX_TIMEOUT_CYC
)
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_start,
  input  wire logic        i_single_wire,
  input  wire logic        i_wr,
  input  wire logic [6:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_crc_en,
  input  wire logic        i_long_wait,
  output logic             o_busy,
  output logic             o_done,
  output logic      [23:0] o_rdata,
  output logic      [2:0]  o_status,
  output logic             o_spi_sclk,
  output logic             o_spi_cs_n,
  output logic             o_spi_mosi,
  input  wire logic        i_spi_miso,
  input  wire logic        i_sw_line_i,
  output logic             o_sw_line_o,
  output logic             o_sw_line_oe
);

  localparam logic [15:0] HALF_LD      = 16'(hsp_pkg::SCLK_HALF_CYC - 1);
  localparam logic [15:0] GAP_LD       = 16'(hsp_pkg::FRAME_GAP_CYC - 1);
  localparam logic [15:0] FILL_LD      = 16'(RESULT_FILL_CYC - 1);
  localparam logic [15:0] BRK_LD       = 16'(BREAK_CYC - 1);
  localparam logic [15:0] BREC_LD      = 16'(hsp_pkg::BREAK_REC_CYC - 1);
  localparam logic [15:0] ZERO_LD      = 16'(hsp_pkg::HOST_ZERO_LOW_CYC - 1);
  localparam logic [15:0] ONE_LD       = 16'(hsp_pkg::HOST_ONE_LOW_CYC - 1);
  localparam logic [15:0] ZERO_REST_LD = 16'(HOST_SLOT_CYC - hsp_pkg::HOST_ZERO_LOW_CYC - 1);
  localparam logic [15:0] ONE_REST_LD  = 16'(HOST_SLOT_CYC - hsp_pkg::HOST_ONE_LOW_CYC - 1);
  localparam logic [15:0] RXTO_LD      = 16'(RX_TIMEOUT_CYC - 1);
  localparam logic [15:0] THRESH       = 16'(hsp_pkg::BIT_THRESH_CYC);

  hsp_pkg::hsp_state_t  state_r;
  hsp_pkg::hsp_status_t status_c;
  logic [15:0] cnt_r;
  logic [4:0]  bit_r;
  logic [1:0]  retry_r;
  logic        again_r;
  logic        timeout_r;
  logic        done_r;
  logic        sclk_r;
  logic        cs_n_r;
  logic        oe_r;
  logic        req_wr_r;
  logic [6:0]  req_addr_r;
  logic [7:0]  req_wdata_r;
  logic        crc_en_r;
  logic        long_r;
  logic        sw_mode_r;
  logic [23:0] tx_r;
  logic [23:0] rx_r;
  logic [23:0] rdata_r;
  logic [2:0]  status_r;
  logic        miso_m_r;
  logic        miso_s_r;
  logic        sw_m_r;
  logic        sw_s_r;
  logic [7:0]  crc_tx;
  logic [7:0]  crc_rx;
  logic        tdone;
  logic        spi_rise;
  logic        spi_fall;
  logic [4:0]  nbits_c;
  logic [23:0] rx_word;
  logic        retry_c;

  hsp_crc8 u_crc_tx
  (
    .i_data ({req_wr_r, req_addr_r, req_wdata_r}),
    .o_crc  (crc_tx)
  );

  hsp_crc8 u_crc_rx
  (
    .i_data (rx_word[23:8]),
    .o_crc  (crc_rx)
  );

  // pin synchronisers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
      sw_m_r   <= 1'b1;
      sw_s_r   <= 1'b1;
    end
    else
    begin
      miso_m_r <= i_spi_miso;
      miso_s_r <= miso_m_r;
      sw_m_r   <= i_sw_line_i;
      sw_s_r   <= sw_m_r;
    end
  end

  assign tdone    = (cnt_r == 16'h0000);
  assign spi_rise = (state_r == hsp_pkg::S_SPI_SHIFT) && tdone && !sclk_r;
  assign spi_fall = (state_r == hsp_pkg::S_SPI_SHIFT) && tdone && sclk_r;
  assign nbits_c  = crc_en_r ? hsp_pkg::FRAME_BITS_CRC : hsp_pkg::FRAME_BITS_PLAIN;
  assign rx_word  = sw_mode_r ? {16'h0000, rx_r[7:0]}
                  : (crc_en_r ? rx_r : {rx_r[15:0], 8'h00});

  // classify the answer of the finished frame
  always_comb
  begin
    status_c = hsp_pkg::ST_OK;
    if (sw_mode_r)
    begin
      if (timeout_r)
        status_c = hsp_pkg::ST_TIMEOUT;
    end
    else if (rx_word[23:8] == hsp_pkg::NO_DATA)
    begin
      if (!crc_en_r || rx_word[7:0] == hsp_pkg::FLAG_UNPOWERED)
        status_c = hsp_pkg::ST_UNPOWERED;
      else if (rx_word[7:0] == hsp_pkg::FLAG_CRC_REJECT)
        status_c = hsp_pkg::ST_CRC_REJECT;
      else if (rx_word[7:0] == hsp_pkg::FLAG_NOT_UPDATED)
        status_c = hsp_pkg::ST_NOT_UPDATED;
      else
        status_c = hsp_pkg::ST_BAD_CRC;
    end
    else if (crc_en_r && rx_word[7:0] != crc_rx)
      status_c = hsp_pkg::ST_BAD_CRC;
  end

  assign retry_c = (status_c == hsp_pkg::ST_UNPOWERED || status_c == hsp_pkg::ST_CRC_REJECT
                 || status_c == hsp_pkg::ST_NOT_UPDATED) && (retry_r != hsp_pkg::MAX_RETRY);

  // sequencing, timing and pin drive
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r   <= hsp_pkg::S_IDLE;
      cnt_r     <= 16'h0000;
      bit_r     <= 5'h00;
      retry_r   <= 2'h0;
      again_r   <= 1'b0;
      timeout_r <= 1'b0;
      done_r    <= 1'b0;
      sclk_r    <= 1'b0;
      cs_n_r    <= 1'b1;
      oe_r      <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!tdone)
        cnt_r <= cnt_r - 16'h0001;
      unique case (state_r)
        hsp_pkg::S_IDLE:
          if (i_start)
          begin
            state_r <= hsp_pkg::S_LOAD;
            retry_r <= 2'h0;
          end
        hsp_pkg::S_LOAD:
        begin
          bit_r     <= 5'h00;
          timeout_r <= 1'b0;
          if (sw_mode_r)
          begin
            state_r <= hsp_pkg::S_SW_BREAK;
            cnt_r   <= BRK_LD;
            oe_r    <= 1'b1;
          end
          else
          begin
            state_r <= hsp_pkg::S_SPI_SHIFT;
            cnt_r   <= HALF_LD;
            cs_n_r  <= 1'b0;
          end
        end
        hsp_pkg::S_SPI_SHIFT:
          if (tdone)
          begin
            cnt_r  <= HALF_LD;
            sclk_r <= ~sclk_r;
            if (sclk_r)
            begin
              bit_r <= bit_r + 5'h01;
              if (bit_r == nbits_c - 5'h01)
                state_r <= hsp_pkg::S_SPI_HOLD;
            end
          end
        hsp_pkg::S_SPI_HOLD:
          if (tdone)
          begin
            cs_n_r  <= 1'b1;
            state_r <= hsp_pkg::S_EVAL;
          end
        hsp_pkg::S_SW_BREAK:
          if (tdone)
          begin
            oe_r    <= 1'b0;
            cnt_r   <= BREC_LD;
            state_r <= hsp_pkg::S_SW_BREC;
          end
        hsp_pkg::S_SW_BREC:
          if (tdone)
          begin
            oe_r    <= 1'b1;
            cnt_r   <= tx_r[0] ? ONE_LD : ZERO_LD;
            state_r <= hsp_pkg::S_SW_TXLOW;
          end
        hsp_pkg::S_SW_TXLOW:
          if (tdone)
          begin
            oe_r    <= 1'b0;
            cnt_r   <= tx_r[0] ? ONE_REST_LD : ZERO_REST_LD;
            state_r <= hsp_pkg::S_SW_TXHIGH;
          end
        hsp_pkg::S_SW_TXHIGH:
          if (tdone)
          begin
            bit_r <= bit_r + 5'h01;
            if (bit_r == hsp_pkg::SW_CMD_BITS - 5'h01 && !req_wr_r)
            begin
              state_r <= hsp_pkg::S_SW_RXWAIT;
              cnt_r   <= RXTO_LD;
            end
            else if (bit_r == hsp_pkg::SW_XFER_BITS - 5'h01)
              state_r <= hsp_pkg::S_EVAL;
            else
            begin
              oe_r    <= 1'b1;
              cnt_r   <= tx_r[1] ? ONE_LD : ZERO_LD;
              state_r <= hsp_pkg::S_SW_TXLOW;
            end
          end
        hsp_pkg::S_SW_RXWAIT:
          if (!sw_s_r)
          begin
            state_r <= hsp_pkg::S_SW_RXLOW;
            cnt_r   <= 16'h0000;
          end
          else if (tdone)
          begin
            timeout_r <= 1'b1;
            state_r   <= hsp_pkg::S_EVAL;
          end
        hsp_pkg::S_SW_RXLOW:
          if (sw_s_r)
          begin
            bit_r <= bit_r + 5'h01;
            if (bit_r == hsp_pkg::SW_XFER_BITS - 5'h01)
              state_r <= hsp_pkg::S_EVAL;
            else
            begin
              state_r <= hsp_pkg::S_SW_RXWAIT;
              cnt_r   <= RXTO_LD;
            end
          end
          else if (cnt_r == RXTO_LD)
          begin
            timeout_r <= 1'b1;
            state_r   <= hsp_pkg::S_EVAL;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        hsp_pkg::S_EVAL:
        begin
          state_r <= hsp_pkg::S_GAP;
          cnt_r   <= long_r ? FILL_LD : GAP_LD;
          again_r <= retry_c;
          if (retry_c)
            retry_r <= retry_r + 2'h1;
          else
            done_r <= 1'b1;
        end
        hsp_pkg::S_GAP:
          if (tdone)
            state_r <= again_r ? hsp_pkg::S_LOAD : hsp_pkg::S_IDLE;
        default:
          state_r <= hsp_pkg::S_IDLE;
      endcase
    end
  end

  // request latch and shift registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      req_wr_r    <= 1'b0;
      req_addr_r  <= 7'h00;
      req_wdata_r <= 8'h00;
      crc_en_r    <= 1'b0;
      long_r      <= 1'b0;
      sw_mode_r   <= 1'b0;
      tx_r        <= 24'h000000;
      rx_r        <= 24'h000000;
    end
    else
    begin
      if (state_r == hsp_pkg::S_IDLE && i_start)
      begin
        req_wr_r    <= i_wr;
        req_addr_r  <= i_addr;
        req_wdata_r <= i_wdata;
        crc_en_r    <= i_crc_en;
        long_r      <= i_long_wait;
        sw_mode_r   <= i_single_wire;
      end
      if (state_r == hsp_pkg::S_LOAD)
      begin
        rx_r <= 24'h000000;
        if (sw_mode_r)
          tx_r <= {8'h00, req_wdata_r, req_wr_r, req_addr_r};
        else
          tx_r <= {req_wr_r, req_addr_r, req_wdata_r, crc_tx};
      end
      else if (spi_fall)
        tx_r <= {tx_r[22:0], 1'b0};
      else if (state_r == hsp_pkg::S_SW_TXHIGH && tdone)
        tx_r <= {1'b0, tx_r[23:1]};
      if (spi_rise)
        rx_r <= {rx_r[22:0], miso_s_r};
      else if (state_r == hsp_pkg::S_SW_RXLOW && sw_s_r)
        rx_r[7:0] <= {(cnt_r < THRESH), rx_r[7:1]};
    end
  end

  // result of a finished request
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdata_r  <= 24'h000000;
      status_r <= 3'h0;
    end
    else if (state_r == hsp_pkg::S_EVAL)
    begin
      rdata_r  <= rx_word;
      status_r <= status_c;
    end
  end

  assign o_busy       = (state_r != hsp_pkg::S_IDLE);
  assign o_done       = done_r;
  assign o_rdata      = rdata_r;
  assign o_status     = status_r;
  assign o_spi_sclk   = sclk_r;
  assign o_spi_cs_n   = cs_n_r;
  assign o_spi_mosi   = tx_r[23];
  assign o_sw_line_o  = 1'b0;
  assign o_sw_line_oe = oe_r;

  // checking helpers
  logic        sclk_d_r;
  logic [4:0]  rise_cnt_r;
  logic [15:0] gap_cnt_r;
  logic [15:0] low_cnt_r;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_d_r   <= 1'b0;
      rise_cnt_r <= 5'h00;
      gap_cnt_r  <= 16'hffff;
      low_cnt_r  <= 16'h0000;
    end
    else
    begin
      sclk_d_r <= sclk_r;
      if (cs_n_r)
        rise_cnt_r <= 5'h00;
      else if (sclk_r && !sclk_d_r)
        rise_cnt_r <= rise_cnt_r + 5'h01;
      if (!cs_n_r)
        gap_cnt_r <= 16'h0000;
      else if (gap_cnt_r != 16'hffff)
        gap_cnt_r <= gap_cnt_r + 16'h0001;
      low_cnt_r <= oe_r ? low_cnt_r + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_sw_start;
    $rose(o_sw_line_oe) && state_r == hsp_pkg::S_SW_BREAK;
  endsequence

  sequence s_eval_retry;
    state_r == hsp_pkg::S_EVAL && retry_c;
  endsequence

  property p_frame_len;
    $rose(o_spi_cs_n) |->
      rise_cnt_r == (crc_en_r ? hsp_pkg::FRAME_BITS_CRC : hsp_pkg::FRAME_BITS_PLAIN);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("wrong clock count in frame");

  property p_idle_low;
    o_spi_cs_n |-> !o_spi_sclk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("sclk not low while idle");

  property p_mosi_hold;
    o_spi_sclk |-> $stable(o_spi_mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sclk high");

  property p_dir_first;
    $fell(o_spi_cs_n) |-> o_spi_mosi == req_wr_r && tx_r[22:16] == req_addr_r;
  endproperty
  a_dir_first: assert property (p_dir_first) else $error("frame does not open with dir");

  property p_crc_out;
    $fell(o_spi_cs_n) && crc_en_r |-> tx_r[7:0] == crc_tx && tx_r[15:8] == req_wdata_r;
  endproperty
  a_crc_out: assert property (p_crc_out) else $error("third byte is not the crc");

  property p_gap;
    $fell(o_spi_cs_n) |-> gap_cnt_r >= hsp_pkg::FRAME_GAP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("frames spaced too closely");

  property p_retry_end;
    o_done && (o_status == hsp_pkg::ST_UNPOWERED || o_status == hsp_pkg::ST_CRC_REJECT
      || o_status == hsp_pkg::ST_NOT_UPDATED) |-> retry_r == hsp_pkg::MAX_RETRY;
  endproperty
  a_retry_end: assert property (p_retry_end) else $error("gave up before retries");

  property p_retry_resend;
    s_eval_retry |=> state_r == hsp_pkg::S_GAP && again_r && !o_done;
  endproperty
  a_retry_resend: assert property (p_retry_resend) else $error("flagged frame not resent");

  property p_drive_low_only;
    o_sw_line_oe |-> sw_mode_r && (state_r == hsp_pkg::S_SW_BREAK
      || state_r == hsp_pkg::S_SW_TXLOW);
  endproperty
  a_drive_low_only: assert property (p_drive_low_only) else $error("line driven off slot");

  property p_break_len;
    $fell(o_sw_line_oe) && $past(state_r) == hsp_pkg::S_SW_BREAK |-> low_cnt_r == BREAK_CYC;
  endproperty
  a_break_len: assert property (p_break_len) else $error("break length wrong");

  property p_bit_low;
    $fell(o_sw_line_oe) && $past(state_r) == hsp_pkg::S_SW_TXLOW |->
      low_cnt_r == (tx_r[0] ? hsp_pkg::HOST_ONE_LOW_CYC : hsp_pkg::HOST_ZERO_LOW_CYC);
  endproperty
  a_bit_low: assert property (p_bit_low) else $error("bit low time wrong");

  property p_cmd_dir;
    s_sw_start |-> tx_r[7] == req_wr_r && tx_r[6:0] == req_addr_r;
  endproperty
  a_cmd_dir: assert property (p_cmd_dir) else $error("direction not in bit 7");

endmodule : hsp_host_ctrl

// ===== core/hsp_pkg.sv
package hsp_pkg;

  // system clock and link clock
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // spacing between frames and wait for the result buffer
  localparam int FRAME_GAP_US    = 50;
  localparam int FRAME_GAP_CYC   = (FRAME_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESULT_FILL_US  = 200;
  localparam int RESULT_FILL_CYC = (RESULT_FILL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // single-wire link timing
  localparam int BREAK_US              = 200;
  localparam int BREAK_CYC             = (BREAK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BREAK_RECOVERY_TIME_US = 40;
  localparam int BREAK_REC_CYC         =
    (BREAK_RECOVERY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_BIT_SLOT_TIME_US = 190;
  localparam int HOST_SLOT_CYC         =
    (HOST_BIT_SLOT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_ZERO_LOW_TIME_US = 100;
  localparam int HOST_ZERO_LOW_CYC     =
    (HOST_ZERO_LOW_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_ONE_LOW_TIME_US  = 20;
  localparam int HOST_ONE_LOW_CYC      =
    (HOST_ONE_LOW_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_THRESH_US         = 50;
  localparam int BIT_THRESH_CYC        = (BIT_THRESH_US * 1000) / CLK_PERIOD_NS;
  localparam int RX_TIMEOUT_US         = 1000;
  localparam int RX_TIMEOUT_CYC        = (RX_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  localparam int CNT_W = 16;

  // frame shapes
  localparam logic [4:0] FRAME_BITS_PLAIN = 5'h10;
  localparam logic [4:0] FRAME_BITS_CRC   = 5'h18;
  localparam logic [4:0] SW_CMD_BITS      = 5'h08;
  localparam logic [4:0] SW_XFER_BITS     = 5'h10;
  localparam logic [1:0] MAX_RETRY        = 2'h3;

  // checksum x^8+x^2+x+1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // answer patterns
  localparam logic [15:0] NO_DATA          = 16'hffff;
  localparam logic [7:0]  FLAG_UNPOWERED   = 8'hff;
  localparam logic [7:0]  FLAG_CRC_REJECT  = 8'haa;
  localparam logic [7:0]  FLAG_NOT_UPDATED = 8'h00;

  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_LOAD      = 4'h1,
    S_SPI_SHIFT = 4'h2,
    S_SPI_HOLD  = 4'h3,
    S_SW_BREAK  = 4'h4,
    S_SW_BREC   = 4'h5,
    S_SW_TXLOW  = 4'h6,
    S_SW_TXHIGH = 4'h7,
    S_SW_RXWAIT = 4'h8,
    S_SW_RXLOW  = 4'h9,
    S_EVAL      = 4'ha,
    S_GAP       = 4'hb
  } hsp_state_t;

  typedef enum logic [2:0] {
    ST_OK          = 3'h0,
    ST_UNPOWERED   = 3'h1,
    ST_CRC_REJECT  = 3'h2,
    ST_NOT_UPDATED = 3'h3,
    ST_BAD_CRC     = 3'h4,
    ST_TIMEOUT     = 3'h5
  } hsp_status_t;

endpackage : hsp_pkg

// ===== core/hsp_crc8.sv
`timescale 1ns/1ps

module hsp_crc8
(
  input  wire logic [15:0] i_data,
  output logic      [7:0]  o_crc
);

  // msb first over both bytes
  always_comb
  begin
    logic [7:0] c;
    c = hsp_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      if (c[7] ^ i_data[i])
        c = {c[6:0], 1'b0} ^ hsp_pkg::CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    o_crc = c;
  end

endmodule : hsp_crc8

// ===== tb/hsp_tb_pkg.sv
package hsp_tb_pkg;
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 15; k >= 0; k--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
endpackage : hsp_tb_pkg

// ===== tb/hsp_dev_model.sv
`timescale 1ns/1ps
module hsp_dev_model
(
  input  wire logic i_clk,
  input  wire logic i_sclk,
  input  wire logic i_cs_n,
  input  wire logic i_mosi,
  output logic      o_miso,
  input  wire logic i_line,
  output logic      o_line_oe,
  input  wire logic i_asleep,
  input  wire logic i_lazy,
  input  wire logic i_reject,
  input  wire logic i_garble,
  output int        o_frames,
  output logic [7:0] o_sw_cmd
);
  localparam int device_bit_slot_time = 1600;
  localparam int device_zero_low_time = 1400;
  localparam int device_one_low_time  = 200;
  logic [7:0]  mem [128];
  logic [23:0] rx, tx, out_r;
  logic [15:0] r16;
  logic [7:0]  sw_b;
  logic        upd;
  int          n, t;
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 3);
    {o_miso, o_line_oe, upd, o_sw_cmd} = '0;
    o_frames = 0;
    n = 0;
  end
  // answer prepared by the previous frame
  always @(negedge i_cs_n)
  begin
    n = 0;
    tx = i_asleep ? 24'hffffff : (upd ? out_r : 24'hffff00);
    // corrupted checksum on the line when asked
    tx[0] = tx[0] ^ i_garble;
    o_miso = tx[23];
  end
  always @(posedge i_sclk)
    if (!i_cs_n)
    begin
      rx = {rx[22:0], i_mosi};
      n++;
    end
  always @(negedge i_sclk)
    if (!i_cs_n)
    begin
      tx = tx << 1;
      o_miso = tx[23];
    end
  // deselected: line no longer shows the last bit
  always @(posedge i_cs_n)
  begin
    o_miso = ~o_miso;
    o_frames++;
    r16 = (n == 24) ? rx[23:8] : rx[15:0];
    if (!i_asleep)
    begin
      upd = 1'b0;
      if (n == 24 && (i_reject || hsp_tb_pkg::crc8(r16) !== rx[7:0]))
        {out_r, upd} = {24'hffffaa, 1'b1};
      else if (!i_lazy && (n == 24 || n == 16))
      begin
        if (r16[15])
          mem[r16[14:8]] = r16[7:0];
        else
          r16[7:0] = mem[r16[14:8]];
        {out_r, upd} = {r16, hsp_tb_pkg::crc8(r16), 1'b1};
      end
    end
  end
  task automatic rx_bit(output logic v);
    @(negedge i_line);
    t = 0;
    while (i_line !== 1'b1)
    begin
      @(posedge i_clk);
      t++;
    end
    v = (t < 1250);
  endtask : rx_bit
  // responder only: every transfer opens with the host break
  // both links live at once, as right after a swap
  always
  begin
    rx_bit(sw_b[0]);
    for (int j = 0; j < 8; j++)
      rx_bit(o_sw_cmd[j]);
    sw_b = mem[o_sw_cmd[6:0]];
    if (!o_sw_cmd[7])
      repeat (2700) @(posedge i_clk);
    for (int j = 0; j < 8; j++)
      if (o_sw_cmd[7])
        rx_bit(sw_b[j]);
      else
      begin
        o_line_oe <= 1'b1;
        t = sw_b[j] ? device_one_low_time : device_zero_low_time;
        repeat (t) @(posedge i_clk);
        o_line_oe <= 1'b0;
        repeat (device_bit_slot_time - t) @(posedge i_clk);
      end
    mem[o_sw_cmd[6:0]] = sw_b;
  end
endmodule : hsp_dev_model

// ===== tb/tb_host_serial_slave_port.sv
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
    end \
  end
module tb_host_serial_slave_port;
  logic        i_clk, i_resetn, i_start, i_single_wire, i_wr, i_crc_en, i_long_wait;
  logic [6:0]  i_addr;
  logic [7:0]  i_wdata, sw_cmd;
  logic        o_busy, o_done, sclk, cs_n, mosi, miso, sw_o, sw_oe, dev_oe;
  logic [23:0] o_rdata;
  logic [2:0]  o_status;
  logic        asleep, lazy, reject, pv, garble;
  logic [15:0] prev;
  logic [7:0]  mem_b [128];
  logic [26:0] q [$];
  logic [26:0] e;
  int          frames, errors, n_tests;
  wire         sw_line = ~(sw_oe | dev_oe);
  hsp_host_ctrl #(.BREAK_CYC(50), .HOST_SLOT_CYC(2600), .RESULT_FILL_CYC(1300),
    .RX_TIMEOUT_CYC(3000)) DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_start(i_start), .i_single_wire(i_single_wire),
    .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .i_crc_en(i_crc_en),
    .i_long_wait(i_long_wait), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata),
    .o_status(o_status), .o_spi_sclk(sclk), .o_spi_cs_n(cs_n), .o_spi_mosi(mosi),
    .i_spi_miso(miso), .i_sw_line_i(sw_line), .o_sw_line_o(sw_o), .o_sw_line_oe(sw_oe));
  hsp_dev_model u_dev (
    .i_clk(i_clk), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
    .i_line(sw_line), .o_line_oe(dev_oe), .i_asleep(asleep), .i_lazy(lazy),
    .i_reject(reject), .i_garble(garble), .o_frames(frames), .o_sw_cmd(sw_cmd));
  always #20 i_clk = ~i_clk;
  // completions matched in order against the driver's notes
  always @(negedge i_clk)
    if (o_done === 1'b1)
    begin
      if (q.size() == 0)
        `CHECK(o_done, 1'b0)
      else
      begin
        e = q.pop_front();
        `CHECK(o_status, e[26:24])
        `CHECK(o_rdata, e[23:0])
      end
    end
  task automatic wrap_up;
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic do_op(input logic sw, w, input logic [6:0] a, input logic [7:0] d,
                       input logic c, input logic [2:0] st, input logic [23:0] rd, input int fr);
    int f0, k;
    f0 = frames;
    q.push_back({st, rd});
    @(negedge i_clk);
    {i_single_wire, i_wr, i_addr, i_wdata, i_crc_en, i_start} = {sw, w, a, d, c, 1'b1};
    i_long_wait = 1'($urandom);
    @(negedge i_clk);
    i_start = 1'b0;
    k = 0;
    while (o_busy !== 1'b0 && k < 60000)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k == 60000)
    begin
      errors++;
      $display("[FAIL] %0t request never finished", $time);
      wrap_up();
    end
    `CHECK(frames - f0, fr)
  endtask : do_op
  // a good frame answers with the echo of the frame before it
  task automatic norm(input logic w, input logic [6:0] a, input logic [7:0] d, input logic c);
    logic [15:0] s;
    if (w)
      mem_b[a] = d;
    s = {w, a, w ? d : mem_b[a]};
    if (!pv)
      prev = s;
    do_op(1'b0, w, a, d, c, 3'h0, c ? {prev, hsp_tb_pkg::crc8(prev)} : {prev, 8'h00},
          pv ? 1 : 2);
    {prev, pv} = {s, 1'b1};
  endtask : norm
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    {i_clk, i_resetn, i_start, i_single_wire, i_wr, i_crc_en, i_long_wait} = '0;
    {i_addr, i_wdata, asleep, lazy, reject, pv, garble} = '0;
    errors = 0;
    n_tests = 0;
    for (int i = 0; i < 128; i++)
      mem_b[i] = 8'(i * 3);
    void'($urandom(32'hcd5a895b));
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_resetn = 1'b1;
    `CHECK({o_busy, o_done, cs_n, sclk, sw_oe}, 5'b00100)
    norm(1'b1, 7'h12, 8'h5c, 1'b1);
    norm(1'b0, 7'h12, 8'h00, 1'b0);
    repeat (8)
    begin
      {a, d} = 15'($urandom);
      if (a == 7'h7f)
        d = 8'h00;
      norm(1'($urandom), a, d, 1'($urandom));
    end
    asleep = 1'b1;
    do_op(1'b0, 1'b0, 7'h05, 8'h00, 1'b1, 3'h1, 24'hffffff, 4);
    do_op(1'b0, 1'b1, 7'h05, 8'h00, 1'b0, 3'h1, 24'hffff00, 4);
    asleep = 1'b0;
    lazy = 1'b1;
    do_op(1'b0, 1'b1, 7'h20, 8'h11, 1'b1, 3'h0, {prev, hsp_tb_pkg::crc8(prev)}, 1);
    do_op(1'b0, 1'b0, 7'h20, 8'h00, 1'b1, 3'h3, 24'hffff00, 4);
    {lazy, reject, pv} = 3'b010;
    do_op(1'b0, 1'b1, 7'h30, 8'h77, 1'b1, 3'h2, 24'hffffaa, 4);
    reject = 1'b0;
    norm(1'b0, 7'h30, 8'h00, 1'b1);
    garble = 1'b1;
    d = hsp_tb_pkg::crc8(prev) ^ 8'h01;
    do_op(1'b0, 1'b0, 7'h31, 8'h00, 1'b1, 3'h4, {prev, d}, 1);
    garble = 1'b0;
    do_op(1'b1, 1'b0, 7'h2b, 8'h00, 1'b0, 3'h0, {16'h0, mem_b[7'h2b]}, 0);
    `CHECK(sw_cmd, 8'h2b)
    `CHECK(sw_o, 1'b0)
    wrap_up();
  end
endmodule : tb_host_serial_slave_port
